// ===== logic/pfs_pkg.sv
package pfs_pkg;

   // Datapath and pipeline shape
   localparam int PFS_DATA_W      = 64;
   localparam int PFS_NUM_STAGES  = 5;
   localparam int PFS_OPRD_EXC_N  = 9;
   localparam int PFS_ALU_EXC_N   = 3;
   localparam int PFS_DCST_EXC_N  = 6;
   localparam int PFS_BYTE_OFS_W  = 3;

   // Two phases per pipe_clock_cycle, one core clock each
   localparam logic PFS_PHASE_ONE = 1'b0;
   localparam logic PFS_PHASE_TWO = 1'b1;

   // Reset values
   localparam logic [PFS_DATA_W-1:0] PFS_WORD_RST = 64'h0;
   localparam logic                  PFS_FLAG_RST = 1'b0;

   typedef enum logic [2:0] {
      stg_fetch,
      stg_operand_read,
      stg_alu,
      stg_data_cache,
      stg_writeback
   } pfs_stage_t;

   // Listed per stage, highest priority first
   typedef enum logic [4:0] {
      exc_none,
      fetch_address_error_exc,
      nmi_exc,
      fetch_translation_exc,
      fetch_parity_error_exc,
      interrupt_exc,
      fetch_bus_error_exc,
      system_service_call_exc,
      breakpoint_exc,
      coproc_unusable_exc,
      undefined_opcode_exc,
      trap_exc,
      arith_overflow_exc,
      data_address_error_exc,
      reset_exc,
      data_translation_exc,
      store_to_clean_page_exc,
      data_parity_error_exc,
      address_match_exc,
      data_bus_error_exc
   } pfs_exc_code_t;

   typedef struct packed {
      logic                  phase;
      logic [PFS_DATA_W-1:0] alu_addr;
      logic [PFS_DATA_W-1:0] alu_data;
      logic                  st_dcst;
      logic [PFS_DATA_W-1:0] dcst_addr;
      logic [PFS_DATA_W-1:0] dcst_data;
      logic                  st_wb;
      logic                  wb_hit;
      logic [PFS_DATA_W-1:0] wb_addr;
      logic [PFS_DATA_W-1:0] wb_data;
      logic                  exc_valid;
      pfs_stage_t            exc_stage;
      pfs_exc_code_t         exc_code;
   } pfs_state_t;

endpackage : pfs_pkg

// ===== logic/pfs_exc_if.sv
`timescale 1ns/100ps
interface pfs_exc_if;
   import pfs_pkg::*;

   logic                       fetch_req;
   logic [PFS_OPRD_EXC_N-1:0]  oprd_req;
   logic [PFS_ALU_EXC_N-1:0]   alu_req;
   logic [PFS_DCST_EXC_N-1:0]  dcst_req;
   logic [3:0]                 hit;
   pfs_exc_code_t [3:0]        code;

   modport requester (output fetch_req, oprd_req, alu_req, dcst_req,
                      input  hit, code);
   modport resolver  (input  fetch_req, oprd_req, alu_req, dcst_req,
                      output hit, code);
endinterface : pfs_exc_if

// ===== logic/pfs_prio.sv
`timescale 1ns/100ps
module pfs_prio
   import pfs_pkg::*;
(
   // Per-stage requests and winners
   pfs_exc_if.resolver exc
);

   // Bit 0 is the highest priority
   function automatic logic [4:0] first_set(input logic [8:0] v);
      logic [4:0] idx;
      idx = 5'h0;
      for (int i = 8; i >= 0; i--)
      begin
         if (v[i])
            idx = 5'(i);
      end
      return idx;
   endfunction : first_set

   always_comb
   begin
      exc.hit[0]  = exc.fetch_req;
      exc.hit[1]  = |exc.oprd_req;
      exc.hit[2]  = |exc.alu_req;
      exc.hit[3]  = |exc.dcst_req;
      exc.code[0] = exc.fetch_req ? fetch_address_error_exc : exc_none;
      exc.code[1] = pfs_exc_code_t'(5'(nmi_exc)
                    + first_set(exc.oprd_req));
      exc.code[2] = pfs_exc_code_t'(5'(trap_exc)
                    + first_set({6'h00, exc.alu_req}));
      exc.code[3] = pfs_exc_code_t'(5'(reset_exc)
                    + first_set({3'h0, exc.dcst_req}));
   end

endmodule : pfs_prio

// ===== logic/pfs_ctrl.sv
`timescale 1ns/100ps
// Operation
// - Store operand bypassed into shifter, byte aligned
// - Address latched phase one, data phase two
// - Writeback writes store data only on hit
// - Store holds cache two cycles; slip follower
// - All fault conditions evaluated every cycle
// - Interlocks in hardware, exceptions to software
// - Each fault tied to one fixed stage
// - Operand read raises four slip interlocks
// - Fetch raises only address error exception
// - Operand read exceptions in fixed priority
// - Alu stage trap, overflow, address error
// - Data cache stage exceptions in fixed priority
// - Earlier listed exception wins within stage
// - Stall interlocks halt whole pipeline
// - Back end advances during slip; bubbles NOP
// - Exception cancels faulting and younger instructions
module pfs_ctrl
   import pfs_pkg::*;
(
   // Clock and reset
   input  wire logic                      CORE_CLK,
   input  wire logic                      RST_N,
   // Stage occupancy
   input  wire logic                      FETCH_VALID,
   input  wire logic                      OPRD_VALID,
   input  wire logic                      ALU_VALID,
   input  wire logic                      DCST_VALID,
   // Store path
   input  wire logic                      ALU_IS_STORE,
   input  wire logic                      ALU_USES_DCACHE,
   input  wire logic [PFS_DATA_W-1:0]     ALU_EFF_ADDR,
   input  wire logic [PFS_DATA_W-1:0]     OPRD_STORE_OPERAND,
   input  wire logic                      ALU_BYPASS_SEL,
   input  wire logic [PFS_DATA_W-1:0]     ALU_BYPASS_DATA,
   input  wire logic                      DCST_HIT,
   // Interlock conditions
   input  wire logic                      OPRD_TRANSLATION_MISS,
   input  wire logic                      OPRD_ICACHE_MISS,
   input  wire logic                      OPRD_LOAD_USE,
   input  wire logic                      OPRD_MULT_BUSY,
   input  wire logic                      OPRD_STORE_LOAD,
   input  wire logic                      OPRD_SYSCOP_WRITE,
   input  wire logic                      DCST_TRANSLATION_MISS,
   input  wire logic                      DCST_CACHE_MISS,
   input  wire logic                      DCST_CACHE_BUSY,
   // Exception conditions, bit 0 highest priority
   input  wire logic                      FETCH_ADDR_ERR,
   input  wire logic [PFS_OPRD_EXC_N-1:0] OPRD_EXC,
   input  wire logic [PFS_ALU_EXC_N-1:0]  ALU_EXC,
   input  wire logic [PFS_DCST_EXC_N-1:0] DCST_EXC,
   // Pipeline control
   output logic                           PIPE_PHASE,
   output logic                           PIPE_ADVANCE,
   output logic                           PIPE_STALL,
   output logic                           SLIP_OPRD,
   output logic                           SLIP_ALU,
   output logic [PFS_NUM_STAGES-1:0]      KILL,
   // Data cache write
   output logic                           DCACHE_WE,
   output logic [PFS_DATA_W-1:0]          DCACHE_WR_ADDR,
   output logic [PFS_DATA_W-1:0]          DCACHE_WR_DATA,
   // Exception report
   output logic                           EXC_VALID,
   output pfs_stage_t                     EXC_STAGE,
   output pfs_exc_code_t                  EXC_CODE
);

   pfs_state_t            st;
   pfs_state_t            next_st;
   pfs_exc_if             exc ();
   logic                  dcst_cancel;
   logic                  alu_cancel;
   logic                  oprd_cancel;
   logic                  fetch_cancel;
   logic                  oprd_stall;
   logic                  dcst_stall;
   logic                  oprd_slip;
   logic                  cache_slip;
   logic                  alu_store;
   logic [PFS_DATA_W-1:0] store_operand;
   logic [PFS_DATA_W-1:0] aligned;

   pfs_prio u_prio
   (
      .exc (exc.resolver)
   );

   // requests gated by their own stage
   assign exc.fetch_req = FETCH_ADDR_ERR & FETCH_VALID;
   assign exc.oprd_req  = OPRD_EXC & {PFS_OPRD_EXC_N{OPRD_VALID}};
   assign exc.alu_req   = ALU_EXC & {PFS_ALU_EXC_N{ALU_VALID}};
   assign exc.dcst_req  = DCST_EXC & {PFS_DCST_EXC_N{DCST_VALID}};

   assign dcst_cancel   = exc.hit[3];
   assign alu_cancel    = dcst_cancel | exc.hit[2];
   assign oprd_cancel   = alu_cancel | exc.hit[1];
   assign fetch_cancel  = oprd_cancel | exc.hit[0];
   assign KILL          = {1'b0, dcst_cancel, alu_cancel, oprd_cancel,
                           fetch_cancel};

   assign oprd_stall = OPRD_VALID & ~oprd_cancel
                       & (OPRD_TRANSLATION_MISS | OPRD_ICACHE_MISS);
   assign dcst_stall = DCST_VALID & ~dcst_cancel
                       & (DCST_TRANSLATION_MISS | DCST_CACHE_MISS
                          | DCST_CACHE_BUSY);
   assign PIPE_STALL = oprd_stall | dcst_stall;

   assign oprd_slip = OPRD_VALID & ~oprd_cancel
                      & (OPRD_LOAD_USE | OPRD_MULT_BUSY
                         | OPRD_STORE_LOAD | OPRD_SYSCOP_WRITE);

   // store in data cache stage still owns the cache next cycle
   assign cache_slip = st.st_dcst & ALU_VALID & ALU_USES_DCACHE
                       & ~alu_cancel;

   // back end keeps moving; slipped stage feeds a bubble
   assign SLIP_ALU     = cache_slip;
   assign SLIP_OPRD    = oprd_slip | cache_slip;
   assign PIPE_PHASE   = st.phase;
   assign PIPE_ADVANCE = (st.phase == PFS_PHASE_TWO) & ~PIPE_STALL;

   assign alu_store = ALU_VALID & ALU_IS_STORE & ~alu_cancel;

   assign store_operand = ALU_BYPASS_SEL ? ALU_BYPASS_DATA
                                         : OPRD_STORE_OPERAND;
   assign aligned = store_operand
                    << {ALU_EFF_ADDR[PFS_BYTE_OFS_W-1:0], 3'b000};

   // write on hit, during phase one of writeback
   assign DCACHE_WE      = st.st_wb & st.wb_hit
                           & (st.phase == PFS_PHASE_ONE);
   assign DCACHE_WR_ADDR = st.wb_addr;
   assign DCACHE_WR_DATA = st.wb_data;

   assign EXC_VALID = st.exc_valid;
   assign EXC_STAGE = st.exc_stage;
   assign EXC_CODE  = st.exc_code;

   always_comb
   begin
      next_st           = st;
      next_st.phase     = ~st.phase;
      next_st.exc_valid = PFS_FLAG_RST;
      // address in phase one, aligned data in phase two
      if (alu_store && st.phase == PFS_PHASE_ONE)
         next_st.alu_addr = ALU_EFF_ADDR;
      if (alu_store && st.phase == PFS_PHASE_TWO)
         next_st.alu_data = aligned;
      // faults sampled at each cycle boundary without a stall
      if (PIPE_ADVANCE)
      begin
         next_st.dcst_addr = st.alu_addr;
         next_st.dcst_data = next_st.alu_data;
         next_st.st_dcst   = alu_store & ~cache_slip;
         next_st.wb_addr   = st.dcst_addr;
         next_st.wb_data   = st.dcst_data;
         next_st.st_wb     = st.st_dcst & ~dcst_cancel;
         next_st.wb_hit    = DCST_HIT;
         next_st.exc_valid = |exc.hit;
         // oldest stage, then its own order
         if (exc.hit[3])
         begin
            next_st.exc_stage = stg_data_cache;
            next_st.exc_code  = exc.code[3];
         end
         else if (exc.hit[2])
         begin
            next_st.exc_stage = stg_alu;
            next_st.exc_code  = exc.code[2];
         end
         else if (exc.hit[1])
         begin
            next_st.exc_stage = stg_operand_read;
            next_st.exc_code  = exc.code[1];
         end
         else if (exc.hit[0])
         begin
            next_st.exc_stage = stg_fetch;
            next_st.exc_code  = exc.code[0];
         end
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         st <= '{phase: PFS_PHASE_ONE, alu_addr: PFS_WORD_RST,
                 alu_data: PFS_WORD_RST, st_dcst: PFS_FLAG_RST,
                 dcst_addr: PFS_WORD_RST, dcst_data: PFS_WORD_RST,
                 st_wb: PFS_FLAG_RST, wb_hit: PFS_FLAG_RST,
                 wb_addr: PFS_WORD_RST, wb_data: PFS_WORD_RST,
                 exc_valid: PFS_FLAG_RST, exc_stage: stg_fetch,
                 exc_code: exc_none};
      else
         st <= next_st;
   end

   AST_ADDR_PHASE_ONE: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      alu_store && st.phase == PFS_PHASE_ONE
      |=> st.alu_addr == $past(ALU_EFF_ADDR))
      else $error("store address not latched in phase one");

   AST_DATA_PHASE_TWO: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      alu_store && st.phase == PFS_PHASE_TWO && !ALU_BYPASS_SEL
      |=> st.alu_data == ($past(OPRD_STORE_OPERAND)
                          << {$past(ALU_EFF_ADDR[2:0]), 3'b000}))
      else $error("aligned store data wrong");

   AST_WRITE_ONLY_HIT: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      DCACHE_WE |-> st.st_wb && st.wb_hit)
      else $error("cache written without store hit");

   AST_WRITE_ON_HIT: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      PIPE_ADVANCE && st.st_dcst && DCST_HIT && !dcst_cancel
      |=> DCACHE_WE && DCACHE_WR_DATA == $past(st.dcst_data))
      else $error("hitting store not written");

   AST_CACHE_SLIP: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      PIPE_ADVANCE && cache_slip |=> !st.st_dcst && st.st_wb)
      else $error("cache slip did not insert a bubble");

   AST_STALL_HOLDS: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      dcst_stall |-> PIPE_STALL && !PIPE_ADVANCE)
      else $error("data cache stall did not halt pipe");

   AST_SLIP_RAISED: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      OPRD_VALID && OPRD_LOAD_USE && !oprd_cancel
      |-> SLIP_OPRD && !SLIP_ALU || cache_slip)
      else $error("load use slip missing");

   AST_KILL_YOUNGER: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      exc.hit[2] |-> KILL[3:0] == {dcst_cancel, 3'b111})
      else $error("younger instructions not cancelled");

   AST_OPRD_PRIORITY: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      PIPE_ADVANCE && OPRD_VALID && OPRD_EXC[0] && !alu_cancel
      |=> EXC_VALID && EXC_CODE == nmi_exc ##1 !EXC_VALID)
      else $error("operand read priority wrong");

   AST_DCST_PRIORITY: assert property (@(posedge CORE_CLK)
      disable iff (!RST_N)
      PIPE_ADVANCE && DCST_VALID && DCST_EXC[5] && DCST_EXC[4]
      && DCST_EXC[3:0] == 4'h0
      |=> EXC_CODE == address_match_exc
          && EXC_STAGE == stg_data_cache)
      else $error("data cache stage priority wrong");

endmodule : pfs_ctrl

// ===== testbench/pfs_dcache_model.sv
`timescale 1ns/100ps
module pfs_dcache_model
   import pfs_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Lookup answer chosen by the bench
   input  wire logic                  hit_en,
   output logic                       hit,
   // Write port
   input  wire logic                  we,
   input  wire logic [PFS_DATA_W-1:0] wr_data,
   output logic [PFS_DATA_W-1:0]      last_word,
   output logic [7:0]                 wr_cnt
);
   assign hit = hit_en;

   // count every write, so a miss that writes shows up
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_word <= PFS_WORD_RST;
         wr_cnt    <= 8'h00;
      end
      else if (we)
      begin
         last_word <= wr_data;
         wr_cnt    <= wr_cnt + 8'h01;
      end
   end
endmodule : pfs_dcache_model

// ===== testbench/test_pipeline_fault_store_control.sv
`timescale 1ns/100ps
module test_pipeline_fault_store_control;
   import pfs_pkg::*;
   logic                      core_clk, rst_n, fv, ov, av, dv, is_st;
   logic                      uses_dc, byp_sel, hit_en, fa_err;
   logic [PFS_DATA_W-1:0]     eff, opnd, byp, wr_addr, wr_data, last_word;
   logic [3:0]                slip_v;
   logic [4:0]                stall_v;
   logic [PFS_OPRD_EXC_N-1:0] o_exc;
   logic [PFS_ALU_EXC_N-1:0]  a_exc;
   logic [PFS_DCST_EXC_N-1:0] d_exc;
   logic                      phase, adv, stall, slip_o, slip_a;
   logic                      dc_we, dc_hit, exc_v;
   logic [PFS_NUM_STAGES-1:0] kill;
   logic [7:0]                wr_cnt;
   pfs_stage_t                exc_stage;
   pfs_exc_code_t             exc_code;
   int                        err_count, total_checks;

   pfs_ctrl u_dut (
      .CORE_CLK(core_clk), .RST_N(rst_n),
      .FETCH_VALID(fv), .OPRD_VALID(ov), .ALU_VALID(av), .DCST_VALID(dv),
      .ALU_IS_STORE(is_st), .ALU_USES_DCACHE(uses_dc),
      .ALU_EFF_ADDR(eff), .OPRD_STORE_OPERAND(opnd),
      .ALU_BYPASS_SEL(byp_sel), .ALU_BYPASS_DATA(byp), .DCST_HIT(dc_hit),
      .OPRD_TRANSLATION_MISS(stall_v[0]), .OPRD_ICACHE_MISS(stall_v[1]),
      .OPRD_LOAD_USE(slip_v[0]), .OPRD_MULT_BUSY(slip_v[1]),
      .OPRD_STORE_LOAD(slip_v[2]), .OPRD_SYSCOP_WRITE(slip_v[3]),
      .DCST_TRANSLATION_MISS(stall_v[2]), .DCST_CACHE_MISS(stall_v[3]),
      .DCST_CACHE_BUSY(stall_v[4]), .FETCH_ADDR_ERR(fa_err),
      .OPRD_EXC(o_exc), .ALU_EXC(a_exc), .DCST_EXC(d_exc),
      .PIPE_PHASE(phase), .PIPE_ADVANCE(adv), .PIPE_STALL(stall),
      .SLIP_OPRD(slip_o), .SLIP_ALU(slip_a), .KILL(kill),
      .DCACHE_WE(dc_we), .DCACHE_WR_ADDR(wr_addr),
      .DCACHE_WR_DATA(wr_data), .EXC_VALID(exc_v),
      .EXC_STAGE(exc_stage), .EXC_CODE(exc_code)
   );

   pfs_dcache_model u_cache (
      .clk(core_clk), .rst_n(rst_n), .hit_en(hit_en), .hit(dc_hit),
      .we(dc_we), .wr_data(wr_data), .last_word(last_word),
      .wr_cnt(wr_cnt)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task test_done;
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : test_done

   task chk(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task tick;
      @(posedge core_clk);
      #10;
   endtask : tick

   // Bounded hunt for the start of a phase one clock
   task to_phase_one;
      int n;
      n = 0;
      tick();
      while (phase !== PFS_PHASE_ONE)
      begin
         n++;
         if (n > 20)
         begin
            err_count++;
            test_done();
         end
         tick();
      end
   endtask : to_phase_one

   // Store with a cache-using follower right behind it
   task store_op(input logic [63:0] a, input logic [63:0] d,
                 input logic sel, input logic h);
      logic [63:0] exp_d;
      logic [7:0]  cnt0;
      exp_d = (sel ? ~d : d) << {a[2:0], 3'h0};
      to_phase_one();
      cnt0 = wr_cnt;
      is_st = 1'b1;
      uses_dc = 1'b1;
      eff = a;
      opnd = 64'hDEAD_BEEF_0BAD_F00D;
      byp = ~d;
      byp_sel = sel;
      hit_en = h;
      tick();
      // Address must already be held; data only now valid
      eff = {~a[63:3], a[2:0]};
      opnd = d;
      tick();
      is_st = 1'b0;
      chk(slip_a, 1'b1);
      tick();
      chk(adv, 1'b1);
      tick();
      chk(dc_we, h);
      chk(slip_a, 1'b0);
      if (h)
      begin
         chk(wr_addr, a);
         chk(wr_data, exp_d);
      end
      uses_dc = 1'b0;
      tick();
      chk(wr_cnt, cnt0 + {7'h00, h});
      if (h)
         chk(last_word, exp_d);
   endtask : store_op

   task interlocks;
      for (int i = 0; i < 4; i++)
      begin
         to_phase_one();
         slip_v = 4'h1 << i;
         tick();
         chk(slip_o, 1'b1);
         chk(stall, 1'b0);
         slip_v = 4'h0;
      end
      for (int i = 0; i < 5; i++)
      begin
         to_phase_one();
         stall_v = 5'h01 << i;
         tick();
         chk(stall, 1'b1);
         chk(adv, 1'b0);
         stall_v = 5'h00;
      end
   endtask : interlocks

   task exc_case(input logic f, input logic [8:0] o, input logic [2:0] a,
                 input logic [5:0] d, input pfs_stage_t s,
                 input pfs_exc_code_t c, input logic [4:0] k);
      to_phase_one();
      fa_err = f;
      o_exc = o;
      a_exc = a;
      d_exc = d;
      tick();
      chk(kill, k);
      tick();
      fa_err = 1'b0;
      o_exc = 9'h000;
      a_exc = 3'h0;
      d_exc = 6'h00;
      chk(exc_v, 1'b1);
      chk(exc_stage, s);
      chk(exc_code, c);
      tick();
      chk(exc_v, 1'b0);
   endtask : exc_case

   // Each winner is tried with every lower entry raised too
   task exc_prio;
      exc_case(1'b1, 9'h000, 3'h0, 6'h00, stg_fetch,
               fetch_address_error_exc, 5'h01);
      for (int i = 0; i < PFS_OPRD_EXC_N; i++)
         exc_case(1'b1, 9'h1FF << i, 3'h0, 6'h00, stg_operand_read,
                  pfs_exc_code_t'(2 + i), 5'h03);
      for (int i = 0; i < PFS_ALU_EXC_N; i++)
         exc_case(1'b1, 9'h1FF, 3'h7 << i, 6'h00, stg_alu,
                  pfs_exc_code_t'(11 + i), 5'h07);
      for (int i = 0; i < PFS_DCST_EXC_N; i++)
         exc_case(1'b1, 9'h1FF, 3'h7, 6'h3F << i, stg_data_cache,
                  pfs_exc_code_t'(14 + i), 5'h0F);
   endtask : exc_prio

   initial
   begin
      rst_n = 1'b0;
      {fv, ov, av, dv} = 4'hF;
      {is_st, uses_dc, byp_sel, hit_en, fa_err} = 5'h00;
      {eff, opnd, byp} = {3{PFS_WORD_RST}};
      slip_v = 4'h0;
      stall_v = 5'h00;
      o_exc = 9'h000;
      a_exc = 3'h0;
      d_exc = 6'h00;
      err_count = 0;
      total_checks = 0;
      repeat (12) @(posedge core_clk);
      #10;
      rst_n = 1'b1;
      store_op(64'h0000_0000_0000_1003, 64'h0000_0000_A5C3_7E19, 1'b0, 1'b1);
      store_op(64'h0000_0000_0000_2007, 64'h1122_3344_5566_7788, 1'b1, 1'b1);
      store_op(64'h0000_0000_0000_3000, 64'h0F0F_0F0F_0F0F_0F0F, 1'b0, 1'b0);
      interlocks();
      exc_prio();
      test_done();
   end
endmodule : test_pipeline_fault_store_control
